/* hdl/apm_pkg.sv */
// Constants and types shared by the alternate pin function multiplexer
package apm_pkg;
    // Command byte layout
    localparam int         CMD_W          = 8;
    localparam logic [4:0] PIN_CMD_TAG    = 5'h1C;  // Upper five bits 11100
    localparam int         PIN_TAG_LSB    = 3;
    localparam int         P2_SEL_BIT     = 2;
    localparam int         P1_SEL_LSB     = 0;
    localparam logic [3:0] BURST_CMD_TAG  = 4'hF;
    localparam int         BURST_TAG_LSB  = 4;
    localparam int         BURST_EN_BIT   = 0;
    localparam logic [7:0] BURST_PIN_CODE = 8'hE1;  // Only code allowed with burst clocks

    // Second pin selections
    localparam logic       P2_DTXW = 1'h0;
    localparam logic       P2_RCLK = 1'h1;
    // First pin selections
    localparam logic [1:0] P1_LSD  = 2'h0;
    localparam logic [1:0] P1_DRXW = 2'h1;
    localparam logic [1:0] P1_RCLK = 2'h2;
    localparam logic [1:0] P1_DTXW = 2'h3;

    // Mode select codes on the mode port
    localparam int         MODE_W         = 3;
    localparam logic [2:0] MODE_NT_ADAPT  = 3'h0;
    localparam logic [2:0] MODE_NT_FIXED  = 3'h1;
    localparam logic [2:0] MODE_TE_MASTER = 3'h2;
    localparam logic [2:0] MODE_TE_SLAVE  = 3'h3;
    localparam logic [2:0] MODE_MONITOR   = 3'h4;

    // Active mode, one-hot
    typedef enum logic [4:0] {
        MD_NTA = 5'h01,
        MD_NTF = 5'h02,
        MD_TEM = 5'h04,
        MD_TES = 5'h08,
        MD_MON = 5'h10
    } apm_mode_t;

    // Reset values
    localparam apm_mode_t  RST_MODE  = MD_NTA;
    localparam logic       RST_P2    = P2_DTXW;
    localparam logic [1:0] RST_P1    = P1_LSD;

    // D channel slot geometry
    localparam int D_BITS    = 2;   // D bits per frame
    localparam int CNT_W     = 8;   // Bit counter width
    localparam int D_TX_POS  = 16;  // Bit index of first transmit D bit
    localparam int D_RX_POS  = 16;  // Bit index of first receive D bit
endpackage

/* hdl/apm_alt_pin_mux.sv */
// Alternate pin function multiplexer for the two multipurpose pins
// Overview of operation
// - Pin command is 11100 then second-pin bit then two first-pin bits.
// - Second pin: 0 transmit window, 1 clock; first pin: detect/rx/clock/tx.
// - Mode change defaults: first pin detect; second clock in TE slave, else tx window.
// - Recovered clock output follows the line-locked clock, usable as shift clock.
// - Line detect is open drain, pulled low only when powered down with signal.
// - Line detect stays released whenever the device is powered up.
// - Receive window idles low, high exactly during receive D bit times.
// - Transmit window idles low, high during sampled D bit times; far side gates it.
// - In NT modes the transmit window pulses once per frame.
// - In TE master, code E1 then F1 turns pins 8, 11, 18 to burst set.
// - Transmit burst clock toggles only in the D slot.
// - D data input sampled on rising burst clock edges within the D slot.
// - Receive burst clock gives exactly two shift periods per frame.
// - Receive D data changes on falling edges of the receive burst clock.
// - Five operating modes, one active, chosen by a mode command.
// - TE master sources the shift clock; TE slave accepts the system clock.
module apm_alt_pin_mux #(
    parameter int TX_POS = apm_pkg::D_TX_POS,
    parameter int RX_POS = apm_pkg::D_RX_POS
) (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_arst_n,
    input  wire logic                      i_mode_valid,
    input  wire logic [apm_pkg::MODE_W-1:0] i_mode_code,
    input  wire logic                      i_cmd_valid,
    input  wire logic [apm_pkg::CMD_W-1:0] i_cmd_byte,
    input  wire logic                      i_powered_up,
    input  wire logic                      i_line_sig_pin,
    input  wire logic                      i_shift_clk_pin,
    input  wire logic                      i_frame_sync_pin,
    input  wire logic                      i_recovered_clk_pin,
    input  wire logic                      i_serial_tx_in,
    input  wire logic                      i_d_data_pin,
    input  wire logic [apm_pkg::D_BITS-1:0] i_d_rx_bits,
    output logic                           o_multipurpose_pin_two,
    output logic                           o_multipurpose_pin_one,
    output logic                           o_multipurpose_pin_one_oe,
    output logic                           o_d_data_pin_is_input,
    output logic                           o_serial_rx_out,
    output logic                           o_serial_rx_oe,
    output logic [apm_pkg::D_BITS-1:0]     o_d_tx_bits,
    output logic                           o_d_tx_valid,
    output logic                           o_shift_clk_out,
    output logic                           o_shift_clk_oe,
    output logic                           o_burst_active
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                       sck_s1;
        logic                       sck_s2;
        logic                       rck_s1;
        logic                       rck_s2;
        logic                       fs_s1;
        logic                       fs_s2;
        logic                       fs_d;
        logic                       lsd_s1;
        logic                       lsd_s2;
        logic                       bx_s1;
        logic                       bx_s2;
        logic                       dd_s1;
        logic                       dd_s2;
        logic                       sck_d;
        apm_pkg::apm_mode_t         mode;
        logic                       p2_pend;
        logic [1:0]                 p1_pend;
        logic                       burst_pend;
        logic                       p2_sel;
        logic [1:0]                 p1_sel;
        logic                       burst_act;
        logic [apm_pkg::CNT_W-1:0]  bitcnt;
        logic                       tx_win;
        logic                       rx_win;
        logic [apm_pkg::D_BITS-1:0] tx_sh;
        logic [apm_pkg::D_BITS-1:0] tx_bits;
        logic                       tx_valid;
        logic [apm_pkg::D_BITS-1:0] rx_sh;
        logic                       rx_out;
        logic                       rx_oe;
        logic                       pin8;
        logic                       pin18;
        logic                       pin18_oe;
        logic                       sck_out;
    } apm_state_t;

    apm_state_t st_r;
    apm_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Mode code to one-hot mode; unknown codes keep the current mode
    function automatic apm_pkg::apm_mode_t decode_mode(
        input logic [apm_pkg::MODE_W-1:0] code,
        input apm_pkg::apm_mode_t         cur
    );
        case (code)
            apm_pkg::MODE_NT_ADAPT:  decode_mode = apm_pkg::MD_NTA;
            apm_pkg::MODE_NT_FIXED:  decode_mode = apm_pkg::MD_NTF;
            apm_pkg::MODE_TE_MASTER: decode_mode = apm_pkg::MD_TEM;
            apm_pkg::MODE_TE_SLAVE:  decode_mode = apm_pkg::MD_TES;
            apm_pkg::MODE_MONITOR:   decode_mode = apm_pkg::MD_MON;
            default:                 decode_mode = cur;
        endcase
    endfunction

    // Bit counter lies inside a D slot starting at pos
    function automatic logic in_slot(
        input logic [apm_pkg::CNT_W-1:0] cnt,
        input int                        pos
    );
        in_slot = (int'(cnt) >= pos) && (int'(cnt) < pos + apm_pkg::D_BITS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic                      sck;
        logic                      sck_rise;
        logic                      sck_fall;
        logic                      frame;
        logic [apm_pkg::CNT_W-1:0] cnt_nxt;
        logic                      txb;
        logic                      rxb;
        int                        idx;
        sck      = 1'b0;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        frame    = 1'b0;
        cnt_nxt  = '0;
        txb      = 1'b0;
        rxb      = 1'b0;
        idx      = 0;
        st_nxt   = st_r;

        // Two-flop synchronisers on every pin input
        st_nxt.sck_s1 = i_shift_clk_pin;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.rck_s1 = i_recovered_clk_pin;
        st_nxt.rck_s2 = st_r.rck_s1;
        st_nxt.fs_s1  = i_frame_sync_pin;
        st_nxt.fs_s2  = st_r.fs_s1;
        st_nxt.fs_d   = st_r.fs_s2;
        st_nxt.lsd_s1 = i_line_sig_pin;
        st_nxt.lsd_s2 = st_r.lsd_s1;
        st_nxt.bx_s1  = i_serial_tx_in;
        st_nxt.bx_s2  = st_r.bx_s1;
        st_nxt.dd_s1  = i_d_data_pin;
        st_nxt.dd_s2  = st_r.dd_s1;

        // Master sources its own shift clock from the recovered clock
        sck = (st_r.mode == apm_pkg::MD_TEM) ? st_r.rck_s2 : st_r.sck_s2;
        st_nxt.sck_d = sck;
        sck_rise = sck & ~st_r.sck_d;
        sck_fall = ~sck & st_r.sck_d;
        frame    = st_r.fs_s2 & ~st_r.fs_d;

        // Commands; a mode change wins over a pin command in the same cycle
        if (i_mode_valid) begin
            st_nxt.mode       = decode_mode(i_mode_code, st_r.mode);
            st_nxt.p1_pend    = apm_pkg::P1_LSD;
            st_nxt.p2_pend    = (st_nxt.mode == apm_pkg::MD_TES) ?
                                apm_pkg::P2_RCLK : apm_pkg::P2_DTXW;
            st_nxt.burst_pend = 1'b0;
        end else if (i_cmd_valid) begin
            if (i_cmd_byte[7:apm_pkg::PIN_TAG_LSB] == apm_pkg::PIN_CMD_TAG) begin
                st_nxt.p2_pend    = i_cmd_byte[apm_pkg::P2_SEL_BIT];
                st_nxt.p1_pend    = i_cmd_byte[apm_pkg::P1_SEL_LSB +: 2];
                st_nxt.burst_pend = 1'b0;  // Any new pin code drops burst set
            end else if (i_cmd_byte[7:apm_pkg::BURST_TAG_LSB] == apm_pkg::BURST_CMD_TAG) begin
                // Burst set only in TE master after the one supported pin code
                st_nxt.burst_pend = i_cmd_byte[apm_pkg::BURST_EN_BIT]
                    && (st_r.mode == apm_pkg::MD_TEM)
                    && ({apm_pkg::PIN_CMD_TAG, st_r.p2_pend, st_r.p1_pend}
                        == apm_pkg::BURST_PIN_CODE);
            end
        end

        // Frame boundary restarts the bit count and commits pending selects
        if (frame) begin
            cnt_nxt          = '0;
            st_nxt.p2_sel    = st_r.p2_pend;
            st_nxt.p1_sel    = st_r.p1_pend;
            st_nxt.burst_act = st_r.burst_pend && (st_r.mode == apm_pkg::MD_TEM);
            st_nxt.rx_sh     = i_d_rx_bits;
        end else if (sck_rise && (st_r.bitcnt != {apm_pkg::CNT_W{1'b1}})) begin
            cnt_nxt = st_r.bitcnt + 1'b1;  // Saturates if frame sync goes missing
        end else begin
            cnt_nxt = st_r.bitcnt;
        end
        st_nxt.bitcnt = cnt_nxt;

        // Windows follow the count, so one pulse per frame
        st_nxt.tx_win = in_slot(cnt_nxt, TX_POS);
        st_nxt.rx_win = in_slot(cnt_nxt, RX_POS);

        // Transmit D bits sampled mid-bit, at the burst clock rising edge
        st_nxt.tx_valid = 1'b0;
        if (sck_fall && st_r.tx_win) begin
            st_nxt.tx_sh = {st_r.tx_sh[apm_pkg::D_BITS-2:0],
                            st_r.burst_act ? st_r.dd_s2 : st_r.bx_s2};
            if (int'(st_r.bitcnt) == TX_POS + apm_pkg::D_BITS - 1) begin
                st_nxt.tx_bits  = st_nxt.tx_sh;
                st_nxt.tx_valid = 1'b1;
            end
        end

        // Receive D bits launched at bit start, msb first, released outside slot
        if (sck_rise || frame) begin
            if (in_slot(cnt_nxt, RX_POS)) begin
                idx           = apm_pkg::D_BITS - 1 - (int'(cnt_nxt) - RX_POS);
                st_nxt.rx_out = st_r.rx_sh[idx];
                st_nxt.rx_oe  = 1'b1;
            end else begin
                st_nxt.rx_oe  = 1'b0;
            end
        end

        // Burst clocks: high in the low half of each slot bit, so edges are
        // at mid-bit (rising) and bit start (falling)
        txb = st_nxt.tx_win & ~sck;
        rxb = st_nxt.rx_win & ~sck;

        // Recovered clock passes straight to a pin, re-timed once
        st_nxt.sck_out = st_r.rck_s2;

        // Second pin
        if (st_r.burst_act) begin
            st_nxt.pin8 = txb;
        end else if (st_r.p2_sel == apm_pkg::P2_RCLK) begin
            st_nxt.pin8 = st_r.rck_s2;
        end else begin
            st_nxt.pin8 = st_nxt.tx_win;
        end

        // First pin; open drain only while it carries line detect
        st_nxt.pin18_oe = 1'b1;
        if (st_r.burst_act) begin
            st_nxt.pin18 = rxb;
        end else begin
            case (st_r.p1_sel)
                apm_pkg::P1_LSD: begin
                    st_nxt.pin18    = 1'b0;
                    st_nxt.pin18_oe = ~i_powered_up & st_r.lsd_s2;
                end
                apm_pkg::P1_DRXW: st_nxt.pin18 = st_nxt.rx_win;
                apm_pkg::P1_RCLK: st_nxt.pin18 = st_r.rck_s2;
                apm_pkg::P1_DTXW: st_nxt.pin18 = st_nxt.tx_win;
                default:          st_nxt.pin18 = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset values give the reset mode's default pin functions
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r         <= '0;
            st_r.mode    <= apm_pkg::RST_MODE;
            st_r.p2_pend <= apm_pkg::RST_P2;
            st_r.p1_pend <= apm_pkg::RST_P1;
            st_r.p2_sel  <= apm_pkg::RST_P2;
            st_r.p1_sel  <= apm_pkg::RST_P1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Pin data all from flops; pin 11 direction follows burst set
    assign o_multipurpose_pin_two    = st_r.pin8;
    assign o_multipurpose_pin_one    = st_r.pin18;
    assign o_multipurpose_pin_one_oe = st_r.pin18_oe;
    assign o_d_data_pin_is_input     = st_r.burst_act;
    assign o_serial_rx_out           = st_r.rx_out;
    assign o_serial_rx_oe            = st_r.rx_oe;
    assign o_d_tx_bits               = st_r.tx_bits;
    assign o_d_tx_valid              = st_r.tx_valid;
    assign o_burst_active            = st_r.burst_act;
    // Shift clock driven only in the master mode
    assign o_shift_clk_out           = st_r.sck_out;
    assign o_shift_clk_oe            = (st_r.mode == apm_pkg::MD_TEM);

endmodule

/* sim/apm_alt_pin_mux_properties.sv */
// Port-level checker for the alternate pin function multiplexer
module apm_alt_pin_mux_properties (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_frame_sync_pin,
    input wire logic o_multipurpose_pin_two,
    input wire logic o_multipurpose_pin_one,
    input wire logic o_d_data_pin_is_input,
    input wire logic o_serial_rx_out,
    input wire logic o_serial_rx_oe,
    input wire logic o_d_tx_valid,
    input wire logic o_shift_clk_oe,
    input wire logic o_burst_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////
    // Half of the receive slot, one shift period
    sequence rx_half;
        o_serial_rx_oe [*8];
    endsequence
    // One transmit burst clock pulse, half a shift period high
    sequence tx_pulse;
        o_multipurpose_pin_two [*4] ##1 !o_multipurpose_pin_two;
    endsequence
    ////////////////////////////////////////////////////////////////
    // Pin edge seen three edges back: two sync flops, then the commit edge
    chk_burst_at_frame: assert property ($changed(o_burst_active) |->
        $past(i_frame_sync_pin, 3) && !$past(i_frame_sync_pin, 4))
        else $error("burst set switched away from a frame edge");
    chk_dpin_with_burst: assert property (o_d_data_pin_is_input == o_burst_active)
        else $error("data pin role differs from burst state");
    chk_burst_needs_tem: assert property (o_burst_active |-> o_shift_clk_oe)
        else $error("burst set active outside master mode");
    chk_rx_slot_len: assert property ($rose(o_serial_rx_oe) |->
        rx_half ##1 rx_half ##1 !o_serial_rx_oe)
        else $error("receive slot is not two shift periods");
    chk_tx_valid_pulse: assert property (o_d_tx_valid |=> !o_d_tx_valid [*8])
        else $error("transmit bits flagged twice in a slot");
    chk_rx_burst_slot: assert property (
        o_burst_active && o_multipurpose_pin_one |-> o_serial_rx_oe)
        else $error("receive burst clock outside the slot");
    chk_rx_data_hold: assert property (o_burst_active && o_multipurpose_pin_one &&
        $past(o_multipurpose_pin_one) |-> $stable(o_serial_rx_out))
        else $error("receive data moved while burst clock high");
    chk_tx_burst_shape: assert property (
        o_burst_active && $rose(o_multipurpose_pin_two) |-> tx_pulse)
        else $error("transmit burst pulse has wrong width");
endmodule

bind apm_alt_pin_mux apm_alt_pin_mux_properties u_props (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_frame_sync_pin(i_frame_sync_pin),
    .o_multipurpose_pin_two(o_multipurpose_pin_two),
    .o_multipurpose_pin_one(o_multipurpose_pin_one),
    .o_d_data_pin_is_input(o_d_data_pin_is_input), .o_serial_rx_out(o_serial_rx_out),
    .o_serial_rx_oe(o_serial_rx_oe), .o_d_tx_valid(o_d_tx_valid),
    .o_shift_clk_oe(o_shift_clk_oe), .o_burst_active(o_burst_active)
);

/* sim/apm_far_model.sv */
// Far side controller model: shift clock, frame sync and D channel data
module apm_far_model #(
    parameter int TX_POS = 16
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    input  wire logic [1:0] i_tx_pat,
    output logic            o_shift_clk,
    output logic            o_frame_sync,
    output logic            o_tx_data,
    output logic            o_d_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r;
    int         bit_idx;
    // Frame of 32 shift periods; slow enough for the input synchronisers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // Bit k starts at the k-th rising shift edge after the frame edge
    assign bit_idx      = (int'(cnt_r) + 4) / 8;
    assign o_shift_clk  = cnt_r[2];
    assign o_frame_sync = cnt_r < 8'h08;
    // Slot bits MSB first; outside the slot the line keeps toggling
    assign o_tx_data = bit_idx == TX_POS ? i_tx_pat[1] :
                       bit_idx == TX_POS + 1 ? i_tx_pat[0] : cnt_r[3];
    // Inverse data on the D input pin so the burst route is told apart
    assign o_d_data  = bit_idx == TX_POS ? ~i_tx_pat[1] :
                       bit_idx == TX_POS + 1 ? ~i_tx_pat[0] : ~cnt_r[3];
endmodule

/* sim/tb_apm_alt_pin_mux.sv */
// Self-checking bench for the alternate pin function multiplexer
module tb_apm_alt_pin_mux;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         TXP      = 16;
    localparam int         RXP      = 20;
    localparam logic [1:0] PAT      = 2'h2;
    localparam int         RISES[5] = '{0, 1, 32, 1, 2};
    localparam int         HIGHS[5] = '{256, 16, 128, 16, 8};
    logic       i_ref_clk, i_arst_n, i_mode_valid, i_cmd_valid, i_powered_up, i_line_sig_pin;
    logic [2:0] i_mode_code;
    logic [7:0] i_cmd_byte;
    logic [1:0] i_d_rx_bits, txb;
    logic       sclk, fsync, txd, dd, p2, p1, p1_oe, dpin, rxo, rxoe, txv, sck_oe, bact;
    wire        p1_lvl     = p1_oe ? p1 : 1'b1;  // Pull-up on the open-drain pin
    int         n_fail     = 0;
    int         num_checks = 0;

    apm_alt_pin_mux #(.TX_POS(TXP), .RX_POS(RXP)) dut (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_mode_valid(i_mode_valid),
        .i_mode_code(i_mode_code), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
        .i_powered_up(i_powered_up), .i_line_sig_pin(i_line_sig_pin),
        .i_shift_clk_pin(sclk), .i_frame_sync_pin(fsync), .i_recovered_clk_pin(sclk),
        .i_serial_tx_in(txd), .i_d_data_pin(dd), .i_d_rx_bits(i_d_rx_bits),
        .o_multipurpose_pin_two(p2), .o_multipurpose_pin_one(p1),
        .o_multipurpose_pin_one_oe(p1_oe), .o_d_data_pin_is_input(dpin),
        .o_serial_rx_out(rxo), .o_serial_rx_oe(rxoe), .o_d_tx_bits(txb), .o_d_tx_valid(txv),
        .o_shift_clk_out(), .o_shift_clk_oe(sck_oe), .o_burst_active(bact));
    apm_far_model #(.TX_POS(TXP)) u_far (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_tx_pat(PAT), .o_shift_clk(sclk),
        .o_frame_sync(fsync), .o_tx_data(txd), .o_d_data(dd));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // One-cycle mode or command pulse
    task automatic send(input logic is_mode, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_mode_valid <= is_mode;
        i_cmd_valid  <= !is_mode;
        i_cmd_byte   <= v;
        i_mode_code  <= v[2:0];
        @(posedge i_ref_clk);
        i_mode_valid <= 1'b0;
        i_cmd_valid  <= 1'b0;
    endtask
    // Profile one pin over a whole frame: edges, high time, slot position
    task automatic measure(input logic sel, input int kind);
        int   rises = 0;
        int   highs = 0;
        int   off   = 0;
        logic lv;
        logic prev;
        while (fsync) @(posedge i_ref_clk);
        while (!fsync) @(posedge i_ref_clk);
        prev = sel ? p1_lvl : p2;
        for (int i = 0; i < 256; i++) begin
            @(posedge i_ref_clk);
            lv = sel ? p1_lvl : p2;
            if (lv && !prev && rises == 0) off = i;
            rises += int'(lv && !prev);
            highs += int'(lv);
            prev = lv;
        end
        check(9'(rises), 9'(RISES[kind]));
        check(9'(highs), 9'(HIGHS[kind]));
        if (kind == 1 || kind == 3) check(9'((off + 4) / 8), 9'(kind == 1 ? RXP : TXP));
    endtask
    // Receive slot bits, first bit first, sampled mid-bit
    task automatic rx_chk;
        logic b1;
        while (rxoe !== 1'b0) @(posedge i_ref_clk);
        while (rxoe !== 1'b1) @(posedge i_ref_clk);
        tick(4);
        b1 = rxo;
        tick(8);
        check(9'({b1, rxo}), 9'(i_d_rx_bits));
    endtask
    task automatic tx_chk(input logic [1:0] exp);
        do @(posedge i_ref_clk); while (txv !== 1'b1);
        check(9'(txb), 9'(exp));
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    // Watchdog: about twice the expected run
    initial begin
        tick(60000);
        n_fail++;
        results();
    end
    initial begin
        i_arst_n = 1'b0;
        i_mode_valid = 1'b0;
        i_cmd_valid = 1'b0;
        i_mode_code = 3'h0;
        i_cmd_byte = 8'h00;
        i_powered_up = 1'b0;
        i_line_sig_pin = 1'b1;
        i_d_rx_bits = 2'h2;
        tick(5);
        i_arst_n <= 1'b1;
        tick(8);
        check(9'(p1_oe), 9'h001);
        check(9'(p1), 9'h000);
        i_line_sig_pin <= 1'b0;
        tick(8);
        check(9'(p1_oe), 9'h000);
        i_powered_up <= 1'b1;
        i_line_sig_pin <= 1'b1;
        tick(8);
        check(9'(p1_oe), 9'h000);
        // Reset mode NT adaptive suits any wiring
        measure(0, 3);
        measure(1, 0);
        for (int c = 0; c < 8; c++) begin
            send(0, 8'hE0 | 8'(c));
            tick(600);
            measure(0, c[2] ? 2 : 3);
            measure(1, c % 4);
        end
        rx_chk();
        tx_chk(PAT);
        // Committed pin code is discarded by every mode selection
        for (int m = 0; m < 5; m++) begin
            send(0, 8'hE7);
            tick(600);
            send(1, 8'(m));
            tick(600);
            measure(0, m == 3 ? 2 : 3);
            measure(1, 0);
            check(9'(sck_oe), 9'(m == 2));
        end
        send(1, 8'h02);
        send(0, 8'hE1);
        send(0, 8'hF1);
        tick(600);
        check(9'(bact), 9'h001);
        check(9'(dpin), 9'h001);
        measure(0, 4);
        measure(1, 4);
        tx_chk(~PAT);
        rx_chk();
        send(0, 8'hF0);
        tick(600);
        check(9'(bact), 9'h000);
        // Burst command refused after another pin code or outside master mode
        send(0, 8'hE2);
        send(0, 8'hF1);
        tick(600);
        check(9'(bact), 9'h000);
        send(1, 8'h00);
        send(0, 8'hE1);
        send(0, 8'hF1);
        tick(600);
        check(9'(bact), 9'h000);
        results();
    end
endmodule
